// ---- psac_pkg.sv ----
package psac_pkg;

    // ------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 21;
    localparam int BYTE_W = 9;
    localparam int LANES = 4;
    localparam int DATA_W = BYTE_W * LANES;
    localparam int DEPTH = 1 << ADDR_W;
    localparam int CNT_W = 2;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] RST_ADDR = 21'h000000;
    localparam logic [DATA_W-1:0] RST_DATA = 36'h000000000;
    localparam logic [CNT_W-1:0] RST_CNT = 2'h0;
    localparam logic [LANES-1:0] RST_LANES = 4'hf;
    localparam logic [LANES-1:0] ALL_LANES = 4'hf;
    localparam logic [LANES-1:0] NO_LANES = 4'h0;
    localparam logic [CNT_W-1:0] CNT_STEP = 2'h1;

    // ------------------------------------------------------------
    // burst order, as sampled from the strap
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PSAC_ORDER_LINEAR = 2'b01,
        PSAC_ORDER_INTERLEAVED = 2'b10
    } psac_order_e;

endpackage : psac_pkg

// ---- psac_mem_if.sv ----
`timescale 1ns/1ps
// ------------------------------------------------------------
// array port between the access logic and the storage
// ------------------------------------------------------------
interface psac_mem_if;
    logic [psac_pkg::ADDR_W-1:0] addr;
    logic [psac_pkg::DATA_W-1:0] wdata;
    logic [psac_pkg::LANES-1:0] wlanes;
    logic rd_en;
    logic [psac_pkg::DATA_W-1:0] rdata;

    modport ctrl (output addr, output wdata, output wlanes, output rd_en, input rdata);
    modport mem (input addr, input wdata, input wlanes, input rd_en, output rdata);
endinterface : psac_mem_if

// ---- psac_array.sv ----
`timescale 1ns/1ps
// ------------------------------------------------------------
// storage: one array per byte lane, registered read port
// ------------------------------------------------------------
module psac_array (
    input wire logic i_sys_clk,
    psac_mem_if.mem port
);

    // one lane per generate entry so byte writes never touch neighbours
    genvar g;
    generate
        for (g = 0; g < psac_pkg::LANES; g++) begin : g_lane
            logic [psac_pkg::BYTE_W-1:0] store [0:psac_pkg::DEPTH-1];
            logic [psac_pkg::BYTE_W-1:0] rd_byte;

            // write selected lane, read into output register
            always_ff @(posedge i_sys_clk) begin
                if (port.wlanes[g]) begin
                    store[port.addr] <= port.wdata[g*psac_pkg::BYTE_W +: psac_pkg::BYTE_W];
                end
                if (port.rd_en) begin
                    rd_byte <= store[port.addr];
                end
            end

            assign port.rdata[g*psac_pkg::BYTE_W +: psac_pkg::BYTE_W] = rd_byte;
        end
    endgenerate

endmodule : psac_array

// ---- psac_core.sv ----
`timescale 1ns/1ps
// ------------------------------------------------------------
// pipelined synchronous burst sram: access control and data path
// ------------------------------------------------------------
module psac_core (
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    input wire logic [psac_pkg::ADDR_W-1:0] i_addr,
    input wire logic [psac_pkg::DATA_W-1:0] i_data,
    output logic [psac_pkg::DATA_W-1:0] o_data,
    output logic o_data_oe,
    input wire logic i_chip_sel_primary_n,
    input wire logic i_chip_sel_secondary,
    input wire logic i_chip_sel_tertiary_n,
    input wire logic i_processor_addr_strobe_n,
    input wire logic i_controller_addr_strobe_n,
    input wire logic i_burst_step_n,
    input wire logic i_global_write_n,
    input wire logic i_byte_write_enable_n,
    input wire logic [psac_pkg::LANES-1:0] i_byte_lane_select_n,
    input wire logic i_output_enable_n,
    input wire logic i_burst_order
);

    // ------------------------------------------------------------
    // input registers
    // ------------------------------------------------------------
    logic [psac_pkg::ADDR_W-1:0] in_addr;
    logic [psac_pkg::DATA_W-1:0] in_data;
    logic in_cs_primary_n;
    logic in_cs_secondary;
    logic in_cs_tertiary_n;
    logic in_proc_strobe_n;
    logic in_ctrl_strobe_n;
    logic in_step_n;
    logic in_global_write_n;
    logic in_byte_write_enable_n;
    logic [psac_pkg::LANES-1:0] in_lane_sel_n;

    // synchronous pins land in one register each, idle values at reset
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            in_addr <= psac_pkg::RST_ADDR;
            in_data <= psac_pkg::RST_DATA;
            in_cs_primary_n <= 1'b1;
            in_cs_secondary <= 1'b0;
            in_cs_tertiary_n <= 1'b1;
            in_proc_strobe_n <= 1'b1;
            in_ctrl_strobe_n <= 1'b1;
            in_step_n <= 1'b1;
            in_global_write_n <= 1'b1;
            in_byte_write_enable_n <= 1'b1;
            in_lane_sel_n <= psac_pkg::RST_LANES;
        end else begin
            in_addr <= i_addr;
            in_data <= i_data;
            in_cs_primary_n <= i_chip_sel_primary_n;
            in_cs_secondary <= i_chip_sel_secondary;
            in_cs_tertiary_n <= i_chip_sel_tertiary_n;
            in_proc_strobe_n <= i_processor_addr_strobe_n;
            in_ctrl_strobe_n <= i_controller_addr_strobe_n;
            in_step_n <= i_burst_step_n;
            in_global_write_n <= i_global_write_n;
            in_byte_write_enable_n <= i_byte_write_enable_n;
            in_lane_sel_n <= i_byte_lane_select_n;
        end
    end

    // ------------------------------------------------------------
    // asynchronous pins: output enable and burst-order strap
    // ------------------------------------------------------------
    logic oe_meta_n;
    logic oe_sync_n;
    logic order_meta;
    logic order_sync;

    // two flops each; costs two cycles of enable latency but no metastability
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            oe_meta_n <= 1'b1;
            oe_sync_n <= 1'b1;
            order_meta <= 1'b1;
            order_sync <= 1'b1;
        end else begin
            oe_meta_n <= i_output_enable_n;
            oe_sync_n <= oe_meta_n;
            order_meta <= i_burst_order;
            order_sync <= order_meta;
        end
    end

    // strap is assumed static, so no change handling mid-burst
    psac_pkg::psac_order_e order;
    assign order = order_sync ? psac_pkg::PSAC_ORDER_INTERLEAVED : psac_pkg::PSAC_ORDER_LINEAR;

    // ------------------------------------------------------------
    // cycle decode from the registered inputs
    // ------------------------------------------------------------
    wire cs_all_active;
    wire proc_seen;
    wire ctrl_seen;
    wire strobe_load;
    wire start_access;
    wire deselect;
    wire write_ctrl;
    wire [psac_pkg::LANES-1:0] write_lanes;

    // secondary select is the only active-high one
    assign cs_all_active = !in_cs_primary_n && in_cs_secondary && !in_cs_tertiary_n;
    // processor strobe only counts with primary select low
    assign proc_seen = !in_proc_strobe_n && !in_cs_primary_n;
    // controller strobe is dropped only while a recognised processor strobe is low
    assign ctrl_seen = !proc_seen && !in_ctrl_strobe_n;
    assign strobe_load = proc_seen || ctrl_seen;
    assign start_access = strobe_load && cs_all_active;
    assign deselect = strobe_load && !cs_all_active;

    // global write overrides the byte controls
    assign write_lanes = !in_global_write_n ? psac_pkg::ALL_LANES :
                         !in_byte_write_enable_n ? ~in_lane_sel_n :
                         psac_pkg::NO_LANES;
    assign write_ctrl = |write_lanes;

    // ------------------------------------------------------------
    // access state
    // ------------------------------------------------------------
    logic active;
    logic [psac_pkg::ADDR_W-1:psac_pkg::CNT_W] base_addr;
    logic [psac_pkg::CNT_W-1:0] start_bits;
    logic [psac_pkg::CNT_W-1:0] burst_cnt;

    wire continue_cycle;
    wire step_now;
    wire proc_write_ignored;
    wire write_now;
    wire read_now;

    // no recognised strobe while active continues the burst; an ignored processor strobe counts as high
    assign continue_cycle = active && !proc_seen && in_ctrl_strobe_n;
    // advance is honoured only inside an already started access
    assign step_now = continue_cycle && !in_step_n;
    // processor-strobe start: write controls and advance not looked at
    assign proc_write_ignored = start_access && proc_seen;
    assign write_now = (start_access && ctrl_seen && write_ctrl) ||
                       (continue_cycle && write_ctrl);
    // any selected cycle that is not a write reads, so reads chain back to back
    assign read_now = (start_access && (proc_write_ignored || !write_ctrl)) ||
                      (continue_cycle && !write_ctrl);

    // ------------------------------------------------------------
    // burst address generation
    // ------------------------------------------------------------
    wire [psac_pkg::CNT_W-1:0] next_burst_cnt;
    wire [psac_pkg::CNT_W-1:0] use_start;
    wire [psac_pkg::CNT_W-1:0] use_cnt;
    wire [psac_pkg::CNT_W-1:0] low_bits;
    wire [psac_pkg::ADDR_W-1:psac_pkg::CNT_W] use_base;
    wire [psac_pkg::ADDR_W-1:0] cur_addr;

    // two-bit counter wraps by its width
    assign next_burst_cnt = step_now ? burst_cnt + psac_pkg::CNT_STEP : burst_cnt;
    assign use_start = start_access ? in_addr[psac_pkg::CNT_W-1:0] : start_bits;
    assign use_cnt = start_access ? psac_pkg::RST_CNT : next_burst_cnt;
    assign use_base = start_access ? in_addr[psac_pkg::ADDR_W-1:psac_pkg::CNT_W] : base_addr;
    // interleave by xor, linear by modulo-four sum
    assign low_bits = (order == psac_pkg::PSAC_ORDER_LINEAR) ? use_start + use_cnt :
                      use_start ^ use_cnt;
    assign cur_addr = {use_base, low_bits};

    // load on a selecting strobe, drop on a deselecting one
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            active <= 1'b0;
            base_addr <= psac_pkg::RST_ADDR[psac_pkg::ADDR_W-1:psac_pkg::CNT_W];
            start_bits <= psac_pkg::RST_CNT;
            burst_cnt <= psac_pkg::RST_CNT;
        end else if (start_access) begin
            active <= 1'b1;
            base_addr <= use_base;
            start_bits <= use_start;
            burst_cnt <= psac_pkg::RST_CNT;
        end else if (deselect) begin
            active <= 1'b0;
        end else begin
            burst_cnt <= next_burst_cnt;
        end
    end

    // ------------------------------------------------------------
    // array port
    // ------------------------------------------------------------
    psac_mem_if mem_port ();

    assign mem_port.addr = cur_addr;
    assign mem_port.wdata = in_data;
    assign mem_port.wlanes = write_now ? write_lanes : psac_pkg::NO_LANES;
    assign mem_port.rd_en = read_now;

    psac_array u_array (
        .i_sys_clk(i_sys_clk),
        .port(mem_port.mem)
    );

    // ------------------------------------------------------------
    // read pipeline tracking
    // ------------------------------------------------------------
    logic rd_pending;
    logic rd_first;

    // marks which array reads are real and which follow a deselect
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            rd_pending <= 1'b0;
            rd_first <= 1'b0;
        end else begin
            rd_pending <= read_now;
            rd_first <= start_access && !active;
        end
    end

    // ------------------------------------------------------------
    // output register and driver enable
    // ------------------------------------------------------------
    wire next_oe;

    // masked on a write, a deselect, or the first read out of deselect
    assign next_oe = rd_pending && !rd_first && !oe_sync_n &&
                     !write_now && !deselect;

    // data and enable both leave from flops; data held when not reading
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            o_data <= psac_pkg::RST_DATA;
            o_data_oe <= 1'b0;
        end else begin
            if (rd_pending) begin
                o_data <= mem_port.rdata;
            end
            o_data_oe <= next_oe;
        end
    end

endmodule : psac_core

// ---- psac_core_props.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// pin-level checks of the access pipeline
// ----------------------------------------
module psac_core_props (
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    input wire logic [psac_pkg::DATA_W-1:0] o_data,
    input wire logic o_data_oe,
    input wire logic i_chip_sel_primary_n,
    input wire logic i_chip_sel_secondary,
    input wire logic i_chip_sel_tertiary_n,
    input wire logic i_processor_addr_strobe_n,
    input wire logic i_controller_addr_strobe_n,
    input wire logic i_global_write_n,
    input wire logic i_byte_write_enable_n,
    input wire logic [psac_pkg::LANES-1:0] i_byte_lane_select_n,
    input wire logic i_output_enable_n
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_resetn);
    logic [2:0] oe_low;
    // decode of the pins as sampled at each edge
    wire sel_all = !i_chip_sel_primary_n && i_chip_sel_secondary && !i_chip_sel_tertiary_n;
    wire p_go = !i_processor_addr_strobe_n && !i_chip_sel_primary_n;
    wire strobe = p_go || !i_controller_addr_strobe_n;
    wire wr_ctl = !i_global_write_n || (!i_byte_write_enable_n && !(&i_byte_lane_select_n));
    wire rd_start = sel_all && (p_go || (strobe && !wr_ctl));
    wire cwr = sel_all && strobe && !p_go && wr_ctl;
    wire quiet = i_processor_addr_strobe_n && i_controller_addr_strobe_n && !wr_ctl;
    wire oe_on = oe_low == 3'h4 && !i_output_enable_n;
    // output enable is synchronised, so reads are judged only once it has settled
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn || i_output_enable_n) begin
            oe_low <= 3'h0;
        end else if (oe_low != 3'h4) begin
            oe_low <= oe_low + 3'h1;
        end
    end
    sequence s_desel;
        strobe && !sel_all;
    endsequence
    sequence s_rd_pair;
        (rd_start && oe_on) ##1 (rd_start && oe_on) ##1 (quiet && oe_on);
    endsequence
    sequence s_both_gw;
        (rd_start && oe_on) ##1 (rd_start && !i_controller_addr_strobe_n && !i_global_write_n && oe_on)
            ##1 (quiet && oe_on);
    endsequence
    sequence s_proc_wr;
        (rd_start && p_go) ##1 (i_processor_addr_strobe_n && i_controller_addr_strobe_n && !i_global_write_n);
    endsequence
    AST_DESEL_OFF: assert property (s_desel |-> ##2 !o_data_oe ##1 !o_data_oe)
        else $error("data still driven after deselect");
    AST_WRITE_OFF: assert property (cwr |-> ##2 !o_data_oe ##1 !o_data_oe)
        else $error("data driven around a write");
    AST_FIRST_MASK: assert property (s_desel ##1 rd_start |-> ##3 !o_data_oe)
        else $error("first read after deselect was driven");
    AST_BACK_TO_BACK: assert property (s_rd_pair |-> ##2 o_data_oe)
        else $error("second back-to-back read not driven");
    AST_PROC_WINS: assert property (s_both_gw |-> ##2 o_data_oe)
        else $error("controller strobe acted when both strobes low");
    AST_PROC_WRITE: assert property (s_proc_wr |-> ##2 !o_data_oe ##1 !o_data_oe)
        else $error("data driven in second cycle of processor write");
    AST_OE_HIGH: assert property (i_output_enable_n [*5] |-> !o_data_oe)
        else $error("data driven while output enable high");
    AST_HOLD: assert property (s_desel ##1 (i_processor_addr_strobe_n && i_controller_addr_strobe_n) [*2]
            |=> $stable(o_data) ##1 $stable(o_data))
        else $error("read register changed with no read");
endmodule : psac_core_props
bind psac_core psac_core_props i_props (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .o_data(o_data),
    .o_data_oe(o_data_oe), .i_chip_sel_primary_n(i_chip_sel_primary_n), .i_chip_sel_secondary(i_chip_sel_secondary),
    .i_chip_sel_tertiary_n(i_chip_sel_tertiary_n), .i_processor_addr_strobe_n(i_processor_addr_strobe_n),
    .i_controller_addr_strobe_n(i_controller_addr_strobe_n), .i_global_write_n(i_global_write_n),
    .i_byte_write_enable_n(i_byte_write_enable_n), .i_byte_lane_select_n(i_byte_lane_select_n),
    .i_output_enable_n(i_output_enable_n));

// ---- psac_bus_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// shared data lines of the host bus
// ----------------------------------------
module psac_bus_model (
    input wire logic i_sys_clk,
    input wire logic [psac_pkg::DATA_W-1:0] i_host_data,
    input wire logic i_host_drive,
    input wire logic [psac_pkg::DATA_W-1:0] i_dev_data,
    input wire logic i_dev_drive,
    output logic [psac_pkg::DATA_W-1:0] o_bus
);
    logic [psac_pkg::DATA_W-1:0] last = '0;
    // a clash or a floating bus shows inverted stale data, never a clean word
    assign o_bus = (i_dev_drive && !i_host_drive) ? i_dev_data :
        ((i_host_drive && !i_dev_drive) ? i_host_data : ~last);
    always @(posedge i_sys_clk) last <= o_bus;
endmodule : psac_bus_model

// ---- psac_core_tb.sv ----
`timescale 1ns/1ps
module psac_core_tb;
    typedef struct {logic chk; logic oe; logic [psac_pkg::DATA_W-1:0] d;} psac_exp_s;
    // control word {proc, ctrl, primary, secondary, global, byte enable, advance, lanes}
    localparam logic [10:0] K_IDLE = 11'h77f, K_DESEL = 11'h27f, K_CRD = 11'h4ff, K_PRD = 11'h2ff,
        K_GWR = 11'h490, K_BWR = 11'h4d0, K_PW1 = 11'h2af, K_PW2 = 11'h6bf, K_PB2 = 11'h6d0,
        K_BOTH = 11'h0bf, K_ADV = 11'h6ef, K_STAY = 11'h6ff, K_IGN = 11'h3ef;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic [psac_pkg::ADDR_W-1:0] addr = '0;
    logic [psac_pkg::DATA_W-1:0] hd = '0;
    logic hoe = 1'b0;
    logic [10:0] ctl = K_IDLE;
    logic oe_n = 1'b1;
    logic order = 1'b0;
    wire logic [psac_pkg::DATA_W-1:0] bus;
    logic [psac_pkg::DATA_W-1:0] o_data;
    logic o_data_oe;
    logic sel_st, desel_st, oe_want;
    logic [psac_pkg::ADDR_W-1:0] base;
    logic [psac_pkg::ADDR_W-1:0] line [4];
    logic [1:0] cnt;
    logic [3:0] ln;
    logic [psac_pkg::DATA_W-1:0] mem [logic [psac_pkg::ADDR_W-1:0]];
    psac_exp_s q[$];
    int bad_count = 0;
    int n_tests = 0;
    always #5 sys_clk = ~sys_clk;
    psac_core i_dut (.i_sys_clk(sys_clk), .i_resetn(resetn), .i_addr(addr), .i_data(bus), .o_data(o_data),
        .o_data_oe(o_data_oe), .i_chip_sel_primary_n(ctl[8]), .i_chip_sel_secondary(ctl[7]),
        .i_chip_sel_tertiary_n(!ctl[7]), .i_processor_addr_strobe_n(ctl[10]), .i_controller_addr_strobe_n(ctl[9]),
        .i_burst_step_n(ctl[4]), .i_global_write_n(ctl[6]), .i_byte_write_enable_n(ctl[5]),
        .i_byte_lane_select_n(ctl[3:0]), .i_output_enable_n(oe_n), .i_burst_order(order));
    psac_bus_model i_bus (.i_sys_clk(sys_clk), .i_host_data(hd), .i_host_drive(hoe), .i_dev_data(o_data),
        .i_dev_drive(o_data_oe), .o_bus(bus));
    task automatic cmp_bit(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t drive got %b exp %b", $time, got, exp);
        end
    endtask : cmp_bit
    task automatic cmp_word(input logic [psac_pkg::DATA_W-1:0] got, input logic [psac_pkg::DATA_W-1:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t data got %h exp %h", $time, got, exp);
        end
    endtask : cmp_word
    // one bus cycle: drive pins, predict, check the result due three edges later
    task automatic step(input logic [10:0] k, input logic [psac_pkg::ADDR_W-1:0] a);
        logic [psac_pkg::DATA_W-1:0] d;
        logic [psac_pkg::ADDR_W-1:0] ea;
        logic go, wr, rd, first;
        psac_exp_s e;
        d = psac_pkg::DATA_W'({$urandom(), $urandom()});
        @(posedge sys_clk);
        ctl <= k;
        addr <= a;
        hd <= d;
        oe_n <= oe_want;
        go = (!k[10] && !k[8]) || !k[9];
        wr = !k[6] || (!k[5] && k[3:0] != 4'hf);
        rd = 1'b0;
        first = 1'b0;
        if (go && !k[8] && k[7]) begin
            base = a;
            cnt = 2'h0;
            wr = wr && (k[10] || k[8]);
            rd = !wr;
            first = desel_st;
            desel_st = 1'b0;
            sel_st = 1'b1;
        end else if (go) begin
            sel_st = 1'b0;
            desel_st = 1'b1;
            wr = 1'b0;
        end else if (sel_st) begin
            cnt = cnt + {1'b0, !k[4]};
            rd = !wr;
        end else begin
            wr = 1'b0;
        end
        ea = {base[20:2], order ? base[1:0] ^ cnt : base[1:0] + cnt};
        hoe <= wr;
        if ((wr || (go && !sel_st)) && q.size() > 0) q[$].oe = 1'b0;
        if (wr && (!k[6] || mem.exists(ea))) begin
            if (!mem.exists(ea)) mem[ea] = d;
            for (int g = 0; g < 4; g++) if (!k[6] || !k[g]) mem[ea][9*g +: 9] = d[9*g +: 9];
        end
        e.chk = rd && mem.exists(ea);
        e.d = e.chk ? mem[ea] : '0;
        e.oe = rd && !first && !oe_want;
        q.push_back(e);
        @(negedge sys_clk);
        if (q.size() > 3) begin
            e = q.pop_front();
            cmp_bit(o_data_oe, e.oe);
            if (e.chk) cmp_word(o_data, e.d);
        end
    endtask : step
    task automatic do_reset(input logic ord);
        @(posedge sys_clk);
        resetn <= 1'b0;
        order <= ord;
        oe_want = 1'b1;
        repeat (16) @(posedge sys_clk);
        resetn <= 1'b1;
        q.delete();
        sel_st = 1'b0;
        desel_st = 1'b1;
    endtask : do_reset
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : finish_test
    // about 95 cycles per session, so this leaves a wide margin
    initial begin
        #50000;
        bad_count++;
        $display("BAD %0t watchdog expired", $time);
        finish_test();
    end
    initial begin
        void'($urandom(32'h7f0a));
        for (int o = 0; o < 2; o++) begin
            do_reset(o[0]);
            for (int i = 0; i < 4; i++) line[i] = psac_pkg::ADDR_W'($urandom()) & ~21'h3;
            // writes with output enable parked high, lane selects scrambled
            for (int i = 0; i < 16; i++) step(K_GWR | {7'h0, 4'($urandom())}, line[i / 4] | 21'(i % 4));
            for (int i = 0; i < 6; i++) step(K_BWR | {7'h0, 4'($urandom())}, line[i % 4] | 21'(i % 4));
            step(K_PW1, line[0] | 21'h1);
            step(K_PW2, line[3]);
            step(K_PW1, line[1] | 21'h2);
            ln = 4'($urandom());
            step(K_PB2 | {7'h0, ln}, line[2]);
            step(K_DESEL, '0);
            oe_want = 1'b0;
            repeat (5) step(K_DESEL, '0);
            // random back-to-back reads, the first one out of deselect
            for (int i = 0; i < 12; i++) step(($urandom() & 1) ? K_CRD : K_PRD, line[2'($urandom())] | 21'(2'($urandom())));
            step(K_CRD, line[0]);
            step(K_BOTH, line[1] | 21'h3);
            step(K_STAY, '0);
            // bursts from every start offset, wrap, hold and an ignored strobe
            for (int i = 0; i < 4; i++) begin
                step(K_CRD, line[i] | 21'(i));
                repeat (3) step(K_ADV, '0);
                step(K_STAY, '0);
                step(K_IGN, '0);
            end
            step(K_DESEL, '0);
            repeat (2) step(K_IDLE, '0);
            step(K_IGN, '0);
            repeat (3) step(K_IDLE, '0);
            $display("session with burst order %0d done", o);
        end
        finish_test();
    end
endmodule : psac_core_tb
